// *** core/bdsj_core.sv ***
// Execution unit for decimal adjust, decrement, skips, increment and in-page jump.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module bdsj_core
    import bdsj_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // Fetch side
    input wire logic insn_valid,
    input wire logic [15:0] insn,
    output logic insn_ready,
    output logic flush,
    // Register file
    input wire logic [7:0] rf_rdata,
    output logic [7:0] rf_addr,
    output logic rf_rd,
    output logic rf_wr,
    output logic [7:0] rf_wdata,
    // Architectural state
    output logic [7:0] working_accumulator,
    output logic [3:0] flags,
    output logic [15:0] pc,
    output logic [7:0] pc_high_latch,
    output logic [3:0] phase
);
    bdsj_phase_t ph_q, ph_d;
    bdsj_op_t op_q, op_dec;
    logic [15:0] ir_q;
    logic idle_q, idle_d;
    logic [7:0] opnd_q, acc_q, res_q, wd_q, addr_q, plat_q;
    logic [3:0] flg_q, fl_q;
    logic [15:0] pc_q;
    logic busy_q, rd_q, wr_q, fl_flush_q;
    wire [7:0] alu_res;
    wire [3:0] alu_flg;

    bdsj_decode u_dec (
        .insn(insn),
        .op(op_dec)
    );
    bdsj_alu u_alu (
        .op(op_q),
        .acc(acc_q),
        .opnd(opnd_q),
        .flags_in(flg_q),
        .result(alu_res),
        .flags_out(alu_flg)
    );

    wire dbit = ir_q[8];
    wire start = insn_valid && !busy_q;
    wire is_jmp = (op_q == OP_JMP);
    wire to_reg = (op_q == OP_DAW) || dbit;
    wire to_acc = (op_q == OP_DAW) ? !dbit : !dbit;
    wire res_zero = (res_q == 8'h00);
    wire do_skip = ((op_q == OP_DSZ) && res_zero) || ((op_q == OP_DSNZ) && !res_zero);
    wire [15:0] jmp_pc = {pc_q[15:13], ir_q[12:0]};
    wire last_ph = (ph_q == PH_WRITE);
    // The skip is decided from the result registered in the process phase, so the
    // idle cycle can be scheduled at the same write edge.
    wire need_idle = last_ph && !idle_q && (is_jmp || do_skip);

    always_comb
    begin
        case (ph_q)
            PH_DECODE: ph_d = (busy_q || start) ? PH_READ : PH_DECODE;
            PH_READ: ph_d = PH_PROC;
            PH_PROC: ph_d = PH_WRITE;
            PH_WRITE: ph_d = PH_DECODE;
            default: ph_d = PH_DECODE;
        endcase
    end
    assign idle_d = need_idle ? 1'b1 : (last_ph ? 1'b0 : idle_q);

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            ph_q <= PH_DECODE;
            op_q <= OP_NONE;
            ir_q <= 16'h0000;
            idle_q <= 1'b0;
            busy_q <= 1'b0;
            opnd_q <= 8'h00;
            res_q <= 8'h00;
        end
        else
        begin
            ph_q <= ph_d;
            idle_q <= idle_d;
            if (ph_q == PH_DECODE && start)
            begin
                busy_q <= 1'b1;
                ir_q <= insn;
                op_q <= op_dec;
            end
            if (ph_q == PH_READ && !idle_q)
                opnd_q <= rf_rdata;
            if (ph_q == PH_PROC && !idle_q)
                res_q <= alu_res;
            if (last_ph && !need_idle)
                busy_q <= 1'b0;
        end
    end

    // Architectural state and register-file strobes.
    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            acc_q <= RST_ACC;
            flg_q <= RST_FLAGS;
            pc_q <= RST_PC;
            plat_q <= 8'h00;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            wd_q <= 8'h00;
            addr_q <= 8'h00;
            fl_flush_q <= 1'b0;
        end
        else
        begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            fl_flush_q <= 1'b0;
            if (ph_q == PH_DECODE && start)
            begin
                addr_q <= insn[7:0];
                rd_q <= (op_dec != OP_JMP) && (op_dec != OP_NONE);
            end
            if (ph_q == PH_PROC && !idle_q && op_q != OP_JMP && op_q != OP_NONE)
            begin
                wd_q <= alu_res;
                wr_q <= to_reg;
                if (to_acc)
                    acc_q <= alu_res;
                if (op_q == OP_DAW || op_q == OP_DEC || op_q == OP_INC)
                    flg_q <= alu_flg;
            end
            if (last_ph && !idle_q && is_jmp)
            begin
                pc_q <= jmp_pc;
                plat_q <= jmp_pc[15:8];
            end
            else if (last_ph && !idle_q && busy_q)
                pc_q <= pc_q + 16'h0001;
            if (need_idle)
                fl_flush_q <= 1'b1;
        end
    end

    assign rf_addr = addr_q;
    assign rf_rd = rd_q;
    assign rf_wr = wr_q;
    assign rf_wdata = wd_q;
    assign working_accumulator = acc_q;
    assign flags = flg_q;
    assign pc = pc_q;
    assign pc_high_latch = plat_q;
    assign phase = ph_q;
    assign flush = fl_flush_q;
    assign insn_ready = fl_flush_q ? 1'b0 : !busy_q ? 1'b1 : 1'b0;

    a_phase_order: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ph_q == PH_READ) |=> (ph_q == PH_PROC) ##1 (ph_q == PH_WRITE))
        else $error("phase order broken");
    a_jump_latch: assert property (@(posedge clk_sys) disable iff (!nrst)
        (last_ph && !idle_q && is_jmp) |=> (pc_high_latch == pc[15:8]))
        else $error("pc high latch not loaded");
    a_jump_page: assert property (@(posedge clk_sys) disable iff (!nrst)
        (last_ph && !idle_q && is_jmp) |=> (pc[15:13] == $past(pc_q[15:13])))
        else $error("jump left page");
    a_jump_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
        (last_ph && !idle_q && is_jmp) |=> idle_q [*4])
        else $error("jump idle cycle missing");
    a_skip_flush: assert property (@(posedge clk_sys) disable iff (!nrst)
        (last_ph && !idle_q && do_skip) |=> flush ##1 (idle_q && !rf_wr) [*3])
        else $error("skip idle cycle missing");
    a_skip_flags: assert property (@(posedge clk_sys) disable iff (!nrst)
        ((op_q == OP_DSZ || op_q == OP_DSNZ) && ph_q == PH_PROC) |=> $stable(flags))
        else $error("skip op changed flags");
    a_daw_write: assert property (@(posedge clk_sys) disable iff (!nrst)
        (op_q == OP_DAW && ph_q == PH_PROC && !idle_q) |=> rf_wr)
        else $error("adjust not written to location");
    a_dec_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
        (op_q == OP_DEC && ph_q == PH_PROC && !idle_q && alu_res == 8'h00)
        |=> flags[FLG_Z])
        else $error("zero flag not set");
endmodule // bdsj_core

// *** core/bdsj_pkg.sv ***
// Package with opcodes, phases, flag positions and timing for the decimal/decrement/jump unit.
package bdsj_pkg;
    // Opcode patterns on bits 15..9 of the instruction word; the jump pattern is on bits 15..13.
    localparam logic [6:0] OPC_DAW = 7'h17;
    localparam logic [6:0] OPC_DEC = 7'h03;
    localparam logic [6:0] OPC_DSZ = 7'h0B;
    localparam logic [6:0] OPC_DSNZ = 7'h13;
    localparam logic [6:0] OPC_INC = 7'h0A;
    localparam logic [2:0] OPC_JMP = 3'h6;
    // Flag bit positions in the 4-bit status nibble.
    localparam int FLG_C = 0;
    localparam int FLG_DC = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_OV = 3;
    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [3:0] BCD_FIX = 4'h6;
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [15:0] RST_PC = 16'h0000;
    localparam logic [3:0] RST_FLAGS = 4'h0;
    localparam int PHASES = 4;
    typedef enum logic [3:0] {
        PH_DECODE = 4'h1,
        PH_READ = 4'h2,
        PH_PROC = 4'h4,
        PH_WRITE = 4'h8
    } bdsj_phase_t;
    typedef enum logic [5:0] {
        OP_NONE = 6'h00,
        OP_DAW = 6'h01,
        OP_DEC = 6'h02,
        OP_DSZ = 6'h04,
        OP_DSNZ = 6'h08,
        OP_INC = 6'h10,
        OP_JMP = 6'h20
    } bdsj_op_t;
endpackage

// *** core/bdsj_decode.sv ***
// Instruction word classifier.
`timescale 1ns/1ps
module bdsj_decode
    import bdsj_pkg::*;
(
    // Instruction word
    input wire logic [15:0] insn,
    // Class
    output bdsj_op_t op
);
    wire [6:0] hi7 = insn[15:9];
    assign op = (insn[15:13] == OPC_JMP) ? OP_JMP :
                (hi7 == OPC_DAW) ? OP_DAW :
                (hi7 == OPC_DEC) ? OP_DEC :
                (hi7 == OPC_DSZ) ? OP_DSZ :
                (hi7 == OPC_DSNZ) ? OP_DSNZ :
                (hi7 == OPC_INC) ? OP_INC : OP_NONE;
endmodule // bdsj_decode

// *** core/bdsj_alu.sv ***
// Arithmetic for decimal adjust, increment and decrement.
`timescale 1ns/1ps
module bdsj_alu
    import bdsj_pkg::*;
(
    // Operands
    input wire bdsj_op_t op,
    input wire logic [7:0] acc,
    input wire logic [7:0] opnd,
    input wire logic [3:0] flags_in,
    // Results
    output logic [7:0] result,
    output logic [3:0] flags_out
);
    wire lo_fix = (acc[3:0] > BCD_LIMIT) || flags_in[FLG_DC];
    wire hi_fix = (acc[7:4] > BCD_LIMIT) || flags_in[FLG_C];
    wire [4:0] lo_sum = {1'b0, acc[3:0]} + {1'b0, (lo_fix ? BCD_FIX : 4'h0)};
    // Each nibble is fixed on its own; the low nibble's overflow does not ripple upward.
    wire [4:0] hi_sum = {1'b0, acc[7:4]} + {1'b0, (hi_fix ? BCD_FIX : 4'h0)};
    wire inc = (op == OP_INC);
    wire [8:0] ar = inc ? ({1'b0, opnd} + 9'h001) : ({1'b0, opnd} + 9'h0FF);
    wire [4:0] hr = inc ? ({1'b0, opnd[3:0]} + 5'h01) : ({1'b0, opnd[3:0]} + 5'h0F);
    wire ov = inc ? (ar[7:0] == 8'h80) : (ar[7:0] == 8'h7F);
    always_comb
    begin
        result = ar[7:0];
        flags_out = flags_in;
        if (op == OP_DAW)
        begin
            result = {hi_sum[3:0], lo_sum[3:0]};
            flags_out[FLG_C] = hi_sum[4] | flags_in[FLG_C];
        end
        else if (op == OP_DEC || op == OP_INC)
        begin
            // Decrement is add of 0xFF, so carry means no borrow.
            flags_out = {ov, (ar[7:0] == 8'h00), hr[4], ar[8]};
        end
    end
endmodule // bdsj_alu

// *** sim/bdsj_rf_model.sv ***
// Behavioural data register file that faces the execution unit.
`timescale 1ns/1ps
module bdsj_rf_model
(
    // Clock
    input wire logic clk_sys,
    // Access from the unit
    input wire logic [7:0] rf_addr,
    input wire logic rf_rd,
    input wire logic rf_wr,
    input wire logic [7:0] rf_wdata,
    // Read answer
    output logic [7:0] rf_rdata
);
    logic [7:0] mem [256];
    logic [7:0] junk_q;
    initial
    begin
        for (int i = 0; i < 256; i++)
        begin
            mem[i] = i[7:0];
        end
        junk_q = 8'h5A;
    end
    // Data stands only while the read strobe is high; otherwise junk toggles so a
    // sample taken at the wrong edge cannot pass by luck.
    assign rf_rdata = rf_rd ? mem[rf_addr] : junk_q;
    always @(posedge clk_sys)
    begin
        junk_q <= ~junk_q;
        if (rf_wr)
        begin
            mem[rf_addr] <= rf_wdata;
        end
    end
endmodule // bdsj_rf_model

// *** sim/bcd_adjust_dec_skip_jump_exec_tb.sv ***
// Self-checking bench for the decimal adjust, decrement, skip and jump unit.
`timescale 1ns/1ps
module bcd_adjust_dec_skip_jump_exec_tb;
    typedef struct {logic [15:0] w; logic [7:0] a; logic [3:0] f; logic wr; logic [7:0] wd;
        logic sk;} bdsj_row_t;
    logic clk_sys, nrst, insn_valid, insn_ready, flush, rf_rd, rf_wr;
    logic [15:0] insn, pc, p;
    logic [7:0] rf_rdata, rf_addr, rf_wdata, acc, latch;
    logic [3:0] flags, phase;
    int n_errors, tests_run;
    // Each register starts holding its own address, so the address picks the operand.
    bdsj_row_t rows [14] = '{
        '{16'h147F, 8'h80, 4'hA, 1'b0, 8'h00, 1'b0}, '{16'h0700, 8'h80, 4'h0, 1'b1, 8'hFF, 1'b0},
        '{16'h0680, 8'h7F, 4'h9, 1'b0, 8'h00, 1'b0}, '{16'h15FF, 8'h7F, 4'h7, 1'b1, 8'h00, 1'b0},
        '{16'h2E10, 8'hD5, 4'h7, 1'b1, 8'hD5, 1'b0}, '{16'h143B, 8'h3C, 4'h0, 1'b0, 8'h00, 1'b0},
        '{16'h2F11, 8'h3C, 4'h0, 1'b1, 8'h32, 1'b0}, '{16'h14A4, 8'hA5, 4'h0, 1'b0, 8'h00, 1'b0},
        '{16'h2E12, 8'h05, 4'h1, 1'b1, 8'h05, 1'b0}, '{16'h2601, 8'h00, 4'h1, 1'b0, 8'h00, 1'b0},
        '{16'h1701, 8'h00, 4'h1, 1'b1, 8'h00, 1'b1}, '{16'h1603, 8'h02, 4'h1, 1'b0, 8'h00, 1'b0},
        '{16'h2605, 8'h04, 4'h1, 1'b0, 8'h00, 1'b1}, '{16'h2701, 8'h04, 4'h1, 1'b1, 8'hFF, 1'b1}};

    bdsj_core bdsj_core_inst (.clk_sys(clk_sys), .nrst(nrst), .insn_valid(insn_valid),
        .insn(insn), .insn_ready(insn_ready), .flush(flush), .rf_rdata(rf_rdata),
        .rf_addr(rf_addr), .rf_rd(rf_rd), .rf_wr(rf_wr), .rf_wdata(rf_wdata),
        .working_accumulator(acc), .flags(flags), .pc(pc), .pc_high_latch(latch), .phase(phase));
    bdsj_rf_model bdsj_rf_model_inst (.clk_sys(clk_sys), .rf_addr(rf_addr), .rf_rd(rf_rd),
        .rf_wr(rf_wr), .rf_wdata(rf_wdata), .rf_rdata(rf_rdata));

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic end_of_test();
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic run(input logic [15:0] w, input logic [7:0] ea, input logic [3:0] ef,
        input logic ewr, input logic [7:0] ewd, input logic efl);
        int i;
        i = 0;
        @(negedge clk_sys);
        while (!(phase === 4'h1 && insn_ready === 1'b1) && i < 40)
        begin
            @(negedge clk_sys);
            i++;
        end
        if (i >= 40)
        begin
            n_errors++;
            end_of_test();
        end
        @(posedge clk_sys);
        insn <= w;
        insn_valid <= 1'b1;
        @(posedge clk_sys);
        insn_valid <= 1'b0;
        @(negedge clk_sys);
        if (w[15:13] != 3'h6)
            check(16'(rf_rd), 16'h0001);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        check(16'(phase), 16'h0008);
        check(16'(rf_wr), 16'(ewr));
        if (ewr)
            check(16'(rf_wdata), 16'(ewd));
        check(16'(acc), 16'(ea));
        check(16'(flags), 16'(ef));
        @(negedge clk_sys);
        check(16'(flush), 16'(efl));
    endtask

    initial
    begin
        n_errors = 0;
        tests_run = 0;
        nrst = 1'b0;
        insn_valid = 1'b0;
        insn = 16'h0000;
        repeat (11) @(posedge clk_sys);
        #1;
        check(16'(phase), 16'h0001);
        check(pc, 16'h0000);
        @(posedge clk_sys);
        nrst <= 1'b1;
        foreach (rows[k])
        begin
            p = pc;
            run(rows[k].w, rows[k].a, rows[k].f, rows[k].wr, rows[k].wd, rows[k].sk);
            if (!rows[k].sk)
                check(pc, p + 16'h0001);
        end
        // Words offered during the idle cycle of a skip must be ignored.
        run(16'h2731, 8'h04, 4'h1, 1'b1, 8'h30, 1'b1);
        @(posedge clk_sys);
        insn <= 16'h1430;
        insn_valid <= 1'b1;
        repeat (2) @(posedge clk_sys);
        insn_valid <= 1'b0;
        repeat (4)
        begin
            @(negedge clk_sys);
            check(16'(rf_rd), 16'h0000);
        end
        check(16'(acc), 16'h0004);
        run(16'hD234, 8'h04, 4'h1, 1'b0, 8'h00, 1'b1);
        check(pc, 16'h1234);
        check(16'(latch), 16'h0012);
        run(16'hDFFF, 8'h04, 4'h1, 1'b0, 8'h00, 1'b1);
        check(pc, 16'h1FFF);
        check(16'(latch), 16'h001F);
        run(16'h1430, 8'h31, 4'h0, 1'b0, 8'h00, 1'b0);
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        check(pc, 16'h0000);
        check(16'(acc), 16'h0000);
        end_of_test();
    end
endmodule // bcd_adjust_dec_skip_jump_exec_tb
